// >>> drc_pkg.sv
// Package of constants for the dual low-frequency counter block
// What this block does
// - Seconds counter divides 32768 ticks per second
// - Fine prescaler divides by two to 0..15
// - Seconds on crystal, fine on selected source
// - One absolute seconds alarm, fires once only
// - Fine alarm resolves a single 32 kHz cycle
// - Fine absolute alarm plus periodic every 60 units
// - Fine counter drives strobe pulse at target
// - Strobe works regardless of core power mode
// - Capture pin transition latches fine count snapshot
// - Enabled capture wakes chip; raises interrupt only when its mask bit is set
// - Snapshot holds exact 32 kHz cycle too
// - Internal oscillator path can never be disabled
// - Seconds alarm can wake from deepest shutdown
package drc_pkg;
    // Clock and low-frequency figures
    localparam int          CLK_PERIOD_NS  = 10;
    localparam int          LF_FREQ_HZ     = 32768;
    localparam logic [14:0] SEC_DIV_LAST   = 15'(LF_FREQ_HZ - 1);
    localparam logic [5:0]  PERIOD_UNITS   = 6'h3C;
    localparam logic [5:0]  PERIOD_LAST    = PERIOD_UNITS - 6'h01;

    // Register byte offsets
    localparam logic [5:0] OFS_CTRL       = 6'h00;
    localparam logic [5:0] OFS_SEC_COUNT  = 6'h04;
    localparam logic [5:0] OFS_SEC_ALARM  = 6'h08;
    localparam logic [5:0] OFS_FINE_COUNT = 6'h0C;
    localparam logic [5:0] OFS_FINE_ALARM = 6'h10;
    localparam logic [5:0] OFS_FINE_ASUB  = 6'h14;
    localparam logic [5:0] OFS_STROBE_TGT = 6'h18;
    localparam logic [5:0] OFS_CAP_UNITS  = 6'h1C;
    localparam logic [5:0] OFS_CAP_SUB    = 6'h20;
    localparam logic [5:0] OFS_STATUS     = 6'h24;
    localparam logic [5:0] OFS_MASK       = 6'h28;
    localparam logic [5:0] OFS_FINE_SUB   = 6'h2C;

    // Control register fields
    localparam int CTL_SEC_EN   = 0;
    localparam int CTL_FINE_EN  = 1;
    localparam int CTL_SRC_OSC  = 2;
    localparam int CTL_SEC_ARM  = 3;
    localparam int CTL_FALM_EN  = 4;
    localparam int CTL_PER_EN   = 5;
    localparam int CTL_STB_EN   = 6;
    localparam int CTL_CAP_EN   = 7;
    localparam int CTL_EXP_LSB  = 8;
    localparam int CTL_W        = 12;
    localparam logic [CTL_W-1:0] CTRL_RESET = 12'h000;

    // Status and mask fields
    localparam int ST_SEC_ALM  = 0;
    localparam int ST_FINE_ALM = 1;
    localparam int ST_PERIOD   = 2;
    localparam int ST_CAPTURE  = 3;
    localparam int ST_STROBE   = 4;
    localparam int ST_W        = 5;
    localparam logic [ST_W-1:0] ST_RESET = 5'h00;

    // Bus handshake state
    typedef enum logic {DRC_IDLE, DRC_ACK} drc_bus_t;
endpackage

// >>> drc_edge.sv
// Edge detector for a group of synchronous input pins
`timescale 1ns/1ps
`default_nettype none
module drc_edge #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] pin_i,
    output logic      [W-1:0] rise_o,
    output logic      [W-1:0] fall_o
);
    logic [W-1:0] prev_ff;

    // Previous pin level, compared against the present one
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prev_ff <= '0;
        end else begin
            prev_ff <= pin_i;
        end
    end

    assign rise_o = pin_i & ~prev_ff;
    assign fall_o = ~pin_i & prev_ff;
endmodule
`default_nettype wire

// >>> drc_top.sv
// Dual low-frequency counter with alarms, strobe output and capture
//
// The placing of the registers and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module drc_top
    import drc_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic [5:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    input  wire logic        low_freq_crystal_i,
    input  wire logic        low_freq_internal_osc_i,
    input  wire logic        capture_i,
    output logic             strobe_o,
    output logic             irq_o,
    output logic             wake_o
);
    // Merge write data into a register under byte enables
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] wd,
                                          input logic [3:0]  be);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        return (old_v & ~m) | (wd & m);
    endfunction

    drc_bus_t         bus_ff;
    logic [31:0]      rdata_ff;
    logic [CTL_W-1:0] ctrl_ff;
    logic [14:0]      sec_pre_ff;
    logic [31:0]      sec_count_ff;
    logic [31:0]      sec_alarm_ff;
    logic [14:0]      fine_sub_ff;
    logic [31:0]      fine_count_ff;
    logic [31:0]      fine_alarm_ff;
    logic [14:0]      fine_asub_ff;
    logic [31:0]      strobe_tgt_ff;
    logic [5:0]       per_cnt_ff;
    logic [31:0]      cap_units_ff;
    logic [14:0]      cap_sub_ff;
    logic [ST_W-1:0]  status_ff;
    logic [ST_W-1:0]  mask_ff;
    logic             strobe_ff;
    logic             irq_ff;
    logic             wake_ff;
    logic             wreq_ff;

    // Pin edges; the internal oscillator edge is always watched
    logic [2:0] pin_rise;
    logic [2:0] pin_fall;
    drc_edge #(.W(3)) u_edge (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .pin_i   ({capture_i, low_freq_internal_osc_i, low_freq_crystal_i}),
        .rise_o  (pin_rise),
        .fall_o  (pin_fall)
    );

    // Bus decode: a write is acted on in the cycle it is acknowledged, a read one cycle earlier
    wire        acc      = (avs_read_i | avs_write_i) & (bus_ff == DRC_IDLE);
    wire        wr_go    = avs_write_i & (bus_ff == DRC_ACK);
    wire [5:0]  addr     = {avs_address_i[5:2], 2'b00};
    wire        wr_ctrl  = wr_go & (addr == OFS_CTRL);
    wire        wr_sec   = wr_go & (addr == OFS_SEC_COUNT);
    wire        wr_salm  = wr_go & (addr == OFS_SEC_ALARM);
    wire        wr_falm  = wr_go & (addr == OFS_FINE_ALARM);
    wire        wr_fasub = wr_go & (addr == OFS_FINE_ASUB);
    wire        wr_stgt  = wr_go & (addr == OFS_STROBE_TGT);
    wire        wr_stat  = wr_go & (addr == OFS_STATUS);
    wire        wr_mask  = wr_go & (addr == OFS_MASK);
    wire [31:0] wmerge_c = merge({20'h00000, ctrl_ff}, avs_writedata_i, avs_byteenable_i);

    // Control fields
    wire        sec_en   = ctrl_ff[CTL_SEC_EN];
    wire        fine_en  = ctrl_ff[CTL_FINE_EN];
    wire        sec_arm  = ctrl_ff[CTL_SEC_ARM];
    wire [3:0]  exp_sel  = ctrl_ff[CTL_EXP_LSB +: 4];
    wire [14:0] sub_mask = 15'((16'h0001 << exp_sel) - 16'h0001);

    // Seconds chain runs on the crystal only
    wire        sec_lf   = pin_rise[0] & sec_en;
    wire        sec_tick = sec_lf & (sec_pre_ff == SEC_DIV_LAST);
    wire [31:0] sec_inc  = sec_count_ff + 32'h0000_0001;
    wire        sec_hit  = sec_tick & sec_arm & (sec_inc == sec_alarm_ff);

    // Fine chain runs on the selected source
    wire        fine_src  = ctrl_ff[CTL_SRC_OSC] ? pin_rise[1] : pin_rise[0];
    wire        fine_lf   = fine_src & fine_en;
    wire        unit_tick = fine_lf & (fine_sub_ff == sub_mask);
    wire        falm_hit  = fine_lf & ctrl_ff[CTL_FALM_EN] & (fine_count_ff == fine_alarm_ff)
                            & (fine_sub_ff == (fine_asub_ff & sub_mask));
    wire        per_hit   = unit_tick & ctrl_ff[CTL_PER_EN] & (per_cnt_ff == PERIOD_LAST);
    wire        stb_hit   = fine_lf & ctrl_ff[CTL_STB_EN] & (fine_count_ff == strobe_tgt_ff)
                            & (fine_sub_ff == 15'h0000);
    wire        cap_evt   = (pin_rise[2] | pin_fall[2]) & ctrl_ff[CTL_CAP_EN];

    // Events, status update with set winning over clear
    wire [ST_W-1:0] set_vec = {stb_hit, cap_evt, per_hit, falm_hit, sec_hit};
    wire [ST_W-1:0] clr_vec = wr_stat ? avs_writedata_i[ST_W-1:0] : '0;
    wire [ST_W-1:0] nxt_status = (status_ff & ~clr_vec) | set_vec;
    wire            nxt_irq = |(nxt_status & mask_ff);
    // Wake sources stay alive whatever the core clock does
    wire            nxt_wake = (nxt_status[ST_SEC_ALM] & sec_en)
                               | (nxt_status[ST_CAPTURE] & ctrl_ff[CTL_CAP_EN])
                               | |(nxt_status & mask_ff);

    // Read selection, unmapped words read as zero
    wire [31:0] rd_sel =
        (addr == OFS_CTRL)       ? {20'h00000, ctrl_ff} :
        (addr == OFS_SEC_COUNT)  ? sec_count_ff :
        (addr == OFS_SEC_ALARM)  ? sec_alarm_ff :
        (addr == OFS_FINE_COUNT) ? fine_count_ff :
        (addr == OFS_FINE_ALARM) ? fine_alarm_ff :
        (addr == OFS_FINE_ASUB)  ? {17'h00000, fine_asub_ff} :
        (addr == OFS_STROBE_TGT) ? strobe_tgt_ff :
        (addr == OFS_CAP_UNITS)  ? cap_units_ff :
        (addr == OFS_CAP_SUB)    ? {17'h00000, cap_sub_ff} :
        (addr == OFS_STATUS)     ? {27'h0000000, status_ff} :
        (addr == OFS_MASK)       ? {27'h0000000, mask_ff} :
        (addr == OFS_FINE_SUB)   ? {17'h00000, fine_sub_ff} : 32'h0000_0000;

    // Bus handshake: one wait cycle, then a one-cycle acknowledge
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bus_ff   <= DRC_IDLE;
            rdata_ff <= 32'h0000_0000;
        end else begin
            case (bus_ff)
                DRC_IDLE: bus_ff <= acc ? DRC_ACK : DRC_IDLE;
                DRC_ACK:  bus_ff <= DRC_IDLE;
                default:  bus_ff <= DRC_IDLE;
            endcase
            if (acc) begin
                rdata_ff <= rd_sel;
            end
        end
    end

    // Waitrequest has its own flop so the pin never carries decode glitches
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wreq_ff <= 1'b1;
        end else begin
            wreq_ff <= ~acc;
        end
    end
    assign avs_waitrequest_o = wreq_ff;
    assign avs_readdata_o    = rdata_ff;

    // Control; the seconds alarm disarms itself once it fires
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_ff <= CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_ff <= wmerge_c[CTL_W-1:0];
        end else if (sec_hit) begin
            ctrl_ff[CTL_SEC_ARM] <= 1'b0;
        end
    end

    // Seconds counter; a software load restarts the second
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sec_pre_ff   <= 15'h0000;
            sec_count_ff <= 32'h0000_0000;
        end else if (wr_sec) begin
            sec_pre_ff   <= 15'h0000;
            sec_count_ff <= merge(sec_count_ff, avs_writedata_i, avs_byteenable_i);
        end else if (sec_lf) begin
            sec_pre_ff <= sec_tick ? 15'h0000 : sec_pre_ff + 15'h0001;
            if (sec_tick) begin
                sec_count_ff <= sec_inc;
            end
        end
    end

    // Fine counter; a control write restarts the sub-unit divider
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fine_sub_ff   <= 15'h0000;
            fine_count_ff <= 32'h0000_0000;
            per_cnt_ff    <= 6'h00;
        end else if (wr_ctrl) begin
            fine_sub_ff <= 15'h0000;
        end else if (fine_lf) begin
            fine_sub_ff <= unit_tick ? 15'h0000 : fine_sub_ff + 15'h0001;
            if (unit_tick) begin
                fine_count_ff <= fine_count_ff + 32'h0000_0001;
                per_cnt_ff    <= (per_cnt_ff == PERIOD_LAST) ? 6'h00 : per_cnt_ff + 6'h01;
            end
        end
    end

    // Software-written alarm, target and mask registers
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sec_alarm_ff  <= 32'h0000_0000;
            fine_alarm_ff <= 32'h0000_0000;
            fine_asub_ff  <= 15'h0000;
            strobe_tgt_ff <= 32'h0000_0000;
            mask_ff       <= ST_RESET;
        end else begin
            if (wr_salm) sec_alarm_ff <= merge(sec_alarm_ff, avs_writedata_i, avs_byteenable_i);
            if (wr_falm) fine_alarm_ff <= merge(fine_alarm_ff, avs_writedata_i, avs_byteenable_i);
            if (wr_fasub) fine_asub_ff <= avs_writedata_i[14:0];
            if (wr_stgt) strobe_tgt_ff <= merge(strobe_tgt_ff, avs_writedata_i, avs_byteenable_i);
            if (wr_mask) mask_ff <= avs_writedata_i[ST_W-1:0];
        end
    end

    // Capture keeps both the unit count and the exact sub-cycle
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cap_units_ff <= 32'h0000_0000;
            cap_sub_ff   <= 15'h0000;
        end else if (cap_evt) begin
            cap_units_ff <= fine_count_ff;
            cap_sub_ff   <= fine_sub_ff;
        end
    end

    // Strobe lasts one source cycle; it needs no core clock gating term
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            strobe_ff <= 1'b0;
        end else if (stb_hit) begin
            strobe_ff <= 1'b1;
        end else if (fine_src) begin
            strobe_ff <= 1'b0;
        end
    end
    assign strobe_o = strobe_ff;

    // Sticky flags and the registered interrupt and wake levels
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            status_ff <= ST_RESET;
            irq_ff    <= 1'b0;
            wake_ff   <= 1'b0;
        end else begin
            status_ff <= nxt_status;
            irq_ff    <= nxt_irq;
            wake_ff   <= nxt_wake;
        end
    end
    assign irq_o  = irq_ff;
    assign wake_o = wake_ff;

    // Checks on the counting, alarm, capture and bus behaviour
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    chk_sec_advance: assert property (
        (sec_tick && !wr_sec) |=> (sec_count_ff == $past(sec_count_ff) + 32'h0000_0001)
                                  && (sec_pre_ff == 15'h0000))
        else $error("seconds count did not advance on its tick");

    chk_sec_once: assert property (
        (sec_hit && !wr_ctrl) |=> !ctrl_ff[CTL_SEC_ARM] && status_ff[ST_SEC_ALM])
        else $error("seconds alarm did not disarm after firing");

    chk_sub_range: assert property (
        (fine_sub_ff & ~sub_mask) == 15'h0000)
        else $error("fine sub-unit divider beyond prescale range");

    chk_fine_unit: assert property (
        (unit_tick && !wr_ctrl) |=> fine_count_ff == $past(fine_count_ff) + 32'h0000_0001)
        else $error("fine count did not advance on unit tick");

    chk_period_wrap: assert property (
        (unit_tick && !wr_ctrl && per_cnt_ff == PERIOD_LAST) |=> per_cnt_ff == 6'h00)
        else $error("periodic unit counter did not wrap at sixty");

    chk_strobe_pulse: assert property (
        stb_hit |=> strobe_o ##1 (strobe_o || $past(fine_src)))
        else $error("strobe pulse missing after target match");

    chk_capture_snap: assert property (
        cap_evt |=> (cap_sub_ff == $past(fine_sub_ff))
                    && (cap_units_ff == $past(fine_count_ff)) && status_ff[ST_CAPTURE])
        else $error("capture snapshot does not match count");

    chk_irq_follow: assert property (
        |(set_vec & mask_ff) |-> ##[1:2] irq_o)
        else $error("interrupt not raised for masked-in event");

    chk_cap_wake: assert property (
        cap_evt |-> ##[1:2] wake_o)
        else $error("capture event did not raise wake");

    chk_bus_ack: assert property (
        (acc && avs_read_i) |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
        else $error("bus acknowledge not one cycle after request");

    // Counts and flags hold between events; flags, strobe, levels and write acknowledge follow their causes
    chk_sec_hold: assert property (
        !(sec_tick || wr_sec) |=> $stable(sec_count_ff))
        else $error("seconds count moved without a tick");

    chk_fine_hold: assert property (
        !unit_tick |=> $stable(fine_count_ff))
        else $error("fine count moved without a unit tick");

    chk_falm_flag: assert property (
        falm_hit |=> status_ff[ST_FINE_ALM])
        else $error("fine alarm flag not set");

    chk_per_flag: assert property (
        per_hit |=> status_ff[ST_PERIOD])
        else $error("periodic flag not set");

    chk_strobe_low: assert property (
        (fine_src && !stb_hit) |=> !strobe_o)
        else $error("strobe outlived its source cycle");

    chk_sticky_hold: assert property (
        (set_vec == '0 && !wr_stat) |=> $stable(status_ff))
        else $error("status changed with no event or clear");

    chk_irq_level: assert property (
        irq_o == |(status_ff & $past(mask_ff)))
        else $error("interrupt level does not follow flags");

    chk_wake_sec: assert property (
        (status_ff[ST_SEC_ALM] && sec_en && !wr_stat) |=> wake_o)
        else $error("seconds alarm flag gave no wake");

    chk_write_ack: assert property (
        (acc && avs_write_i) |=> !avs_waitrequest_o)
        else $error("write not acknowledged after one wait");

    cov_sec_alarm: cover property (sec_hit);
    cov_fine_alarm: cover property (falm_hit);
    cov_period: cover property (per_hit);
    cov_capture: cover property (cap_evt ##[1:20] (acc && addr == OFS_CAP_SUB));
    cov_strobe: cover property (stb_hit);
endmodule
`default_nettype wire

// >>> drc_sensor_model.sv
// Far-side model: low-frequency sources and the sensor's strobe and capture pins
`timescale 1ns/1ps
`default_nettype none
module drc_sensor_model (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        strobe_i,
    input  wire logic        burst_go_i,
    input  wire logic [15:0] burst_len_i,
    input  wire logic        cap_toggle_i,
    output logic             xtal_o,
    output logic             osc_o,
    output logic             capture_o,
    output logic             busy_o,
    output logic [15:0]      strobe_cnt_o
);
    logic [15:0] left_ff;
    logic        osc_ph_ff;
    logic        strobe_d_ff;

    // Crystal gives exact bursts of ticks and rests low, so counts are known
    assign busy_o = (left_ff != 16'h0000);

    // Burst crystal, free-running oscillator, capture transitions, strobe tally
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            left_ff      <= 16'h0000;
            xtal_o       <= 1'b0;
            osc_o        <= 1'b0;
            osc_ph_ff    <= 1'b0;
            capture_o    <= 1'b0;
            strobe_d_ff  <= 1'b0;
            strobe_cnt_o <= 16'h0000;
        end else begin
            if (burst_go_i) begin
                left_ff <= burst_len_i;
            end else if (busy_o) begin
                xtal_o <= ~xtal_o;
                if (xtal_o) begin
                    left_ff <= left_ff - 16'h0001;
                end
            end
            osc_ph_ff <= ~osc_ph_ff;
            if (osc_ph_ff) begin
                osc_o <= ~osc_o;
            end
            if (cap_toggle_i) begin
                capture_o <= ~capture_o;
            end
            strobe_d_ff <= strobe_i;
            if (strobe_i && !strobe_d_ff) begin
                strobe_cnt_o <= strobe_cnt_o + 16'h0001;
            end
        end
    end
endmodule
`default_nettype wire

// >>> tb.sv
// Self-checking bench for the dual low-frequency counter block
`timescale 1ns/1ps
`default_nettype none
module tb
    import drc_pkg::*;
;
    typedef struct {string nm; logic [31:0] e; logic [31:0] m;} drc_note_t;
    localparam logic [31:0] SEN = 32'h1 << CTL_SEC_EN;
    localparam logic [31:0] FEN = 32'h1 << CTL_FINE_EN;
    localparam logic [31:0] OSC = 32'h1 << CTL_SRC_OSC;
    logic        clk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic [5:0]  adr = 6'h00;
    logic        rd_en = 1'b0;
    logic        wr_en = 1'b0;
    logic [31:0] wdat = 32'h0;
    logic        go = 1'b0;
    logic [15:0] blen = 16'h0;
    logic        ctog = 1'b0;
    logic [3:0]  ben = 4'hF;
    logic [31:0] rdat;
    logic        wreq, strobe, irq, wake, xtal, osc, cap, busy;
    logic [15:0] scnt;
    logic [31:0] a, c, q, s;
    int          k, tot, num_errors = 0, n_checks = 0;
    drc_note_t   notes[$];
    drc_note_t   note;

    always #5 clk_i = ~clk_i;

    drc_top i_drc_top (.clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(adr),
        .avs_read_i(rd_en), .avs_write_i(wr_en), .avs_writedata_i(wdat),
        .avs_byteenable_i(ben), .avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
        .low_freq_crystal_i(xtal), .low_freq_internal_osc_i(osc), .capture_i(cap),
        .strobe_o(strobe), .irq_o(irq), .wake_o(wake));
    drc_sensor_model i_drc_sensor_model (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .strobe_i(strobe), .burst_go_i(go), .burst_len_i(blen), .cap_toggle_i(ctog),
        .xtal_o(xtal), .osc_o(osc), .capture_o(cap), .busy_o(busy), .strobe_cnt_o(scnt));

    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] v);
        n_checks++;
        if (v !== e) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", nm, e, v);
        end
    endtask

    // Request held from launch edge until waitrequest is sampled low
    task automatic bus(input logic w, input logic [5:0] ad, input logic [31:0] d);
        @(posedge clk_i);
        rd_en <= ~w;
        wr_en <= w;
        adr   <= ad;
        wdat  <= d;
        do @(posedge clk_i); while (wreq !== 1'b0);
        q = rdat;
        rd_en <= 1'b0;
        wr_en <= 1'b0;
    endtask

    task automatic wr(input logic [5:0] ad, input logic [31:0] d);
        bus(1'b1, ad, d);
    endtask

    // Expectation noted first; the monitor compares when the answer lands
    task automatic rd(input string nm, input logic [5:0] ad, input logic [31:0] e,
                      input logic [31:0] m);
        notes.push_back('{nm, e, m});
        bus(1'b0, ad, 32'h0);
    endtask

    task automatic rv(input logic [5:0] ad, output logic [31:0] v);
        rd("raw", ad, 32'h0, 32'h0);
        v = q;
    endtask

    task automatic burst(input int n);
        @(posedge clk_i);
        go   <= 1'b1;
        blen <= 16'(n);
        @(posedge clk_i);
        go   <= 1'b0;
        do @(posedge clk_i); while (busy);
        repeat (3) @(posedge clk_i);
    endtask

    task automatic settle;
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Read monitor: a mask of zero marks a value only wanted by the driver
    always @(posedge clk_i) begin
        if (rd_en && wreq === 1'b0 && notes.size() > 0) begin
            note = notes.pop_front();
            if (note.m != 32'h0) begin
                cmp(note.nm, note.e & note.m, rdat & note.m);
            end
        end
    end

    // Longest path is one simulated second of crystal ticks
    initial begin
        repeat (90000) @(posedge clk_i);
        num_errors++;
        $display("unexpected watchdog: expected done seen hang");
        stop_test;
    end

    initial begin
        void'($urandom(32'hF5C3EFEF));
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        rd("ctrl reset", OFS_CTRL, 32'h0, '1);
        rd("status reset", OFS_STATUS, 32'h0, '1);
        s = $urandom();
        wr(OFS_SEC_ALARM, s);
        rd("sec alarm", OFS_SEC_ALARM, s, '1);
        ben <= 4'h3;
        wr(OFS_SEC_ALARM, ~s);
        ben <= 4'hF;
        rd("sec alarm bytes", OFS_SEC_ALARM, {s[31:16], ~s[15:0]}, '1);
        wr(OFS_FINE_COUNT, s);
        rd("fine count ro", OFS_FINE_COUNT, 32'h0, '1);
        wr(6'h30, s);
        rd("unmapped", 6'h30, 32'h0, '1);
        $display("test registers done");
        // Every prescale exponent, random tick counts across unit wraps
        for (int e = 0; e < 16; e++) begin
            wr(OFS_CTRL, FEN | (32'(e) << CTL_EXP_LSB));
            rv(OFS_FINE_COUNT, c);
            k = $urandom_range(150, 1);
            burst(k);
            rd("fine count", OFS_FINE_COUNT, c + 32'(k >> e), '1);
            rd("fine sub", OFS_FINE_SUB, 32'(k) & ((32'h1 << e) - 32'h1), '1);
        end
        $display("test prescaler done");
        wr(OFS_CTRL, FEN | OSC);
        rv(OFS_FINE_COUNT, a);
        repeat (200) @(posedge clk_i);
        rv(OFS_FINE_COUNT, c);
        cmp("osc ticks", 32'h1, 32'((c - a) >= 32'h28 && (c - a) <= 32'h3C));
        wr(OFS_CTRL, FEN);
        rv(OFS_FINE_COUNT, c);
        repeat (100) @(posedge clk_i);
        rd("crystal held", OFS_FINE_COUNT, c, '1);
        $display("test source select done");
        // Alarm must hit one exact source cycle inside a unit of four
        wr(OFS_CTRL, FEN | (32'h2 << CTL_EXP_LSB));
        rv(OFS_FINE_COUNT, c);
        wr(OFS_FINE_ALARM, c + 32'h1);
        wr(OFS_FINE_ASUB, 32'h2);
        wr(OFS_CTRL, FEN | (32'h1 << CTL_FALM_EN) | (32'h2 << CTL_EXP_LSB));
        wr(OFS_STATUS, 32'h1F);
        burst(6);
        rd("fine alarm early", OFS_STATUS, 32'h0, 32'h2);
        burst(1);
        rd("fine alarm", OFS_STATUS, 32'h2, 32'h2);
        settle;
        cmp("irq masked", 32'h0, 32'(irq));
        wr(OFS_MASK, 32'h2);
        settle;
        cmp("irq unmasked", 32'h1, 32'(irq));
        wr(OFS_STATUS, 32'h2);
        settle;
        cmp("irq cleared", 32'h0, 32'(irq));
        $display("test fine alarm done");
        wr(OFS_CTRL, FEN | (32'h1 << CTL_PER_EN));
        wr(OFS_STATUS, 32'h1F);
        for (int i = 0; i < 61; i++) begin
            burst(1);
            rv(OFS_STATUS, s);
            if (s[ST_PERIOD]) break;
        end
        wr(OFS_STATUS, 32'h4);
        burst(59);
        rd("period early", OFS_STATUS, 32'h0, 32'h4);
        burst(1);
        rd("period", OFS_STATUS, 32'h4, 32'h4);
        $display("test periodic done");
        wr(OFS_CTRL, FEN | (32'h1 << CTL_STB_EN));
        rv(OFS_FINE_COUNT, c);
        wr(OFS_STROBE_TGT, c + 32'h2);
        a = 32'(scnt);
        burst(2);
        cmp("strobe early", a, 32'(scnt));
        burst(1);
        cmp("strobe count", a + 32'h1, 32'(scnt));
        cmp("strobe high", 32'h1, 32'(strobe));
        rd("strobe flag", OFS_STATUS, 32'h10, 32'h10);
        burst(1);
        cmp("strobe low", 32'h0, 32'(strobe));
        $display("test strobe done");
        // Both pin edges capture; wake follows the flag even when masked
        wr(OFS_CTRL, FEN | (32'h1 << CTL_CAP_EN) | (32'h3 << CTL_EXP_LSB));
        wr(OFS_MASK, 32'h0);
        wr(OFS_STATUS, 32'h1F);
        rv(OFS_FINE_COUNT, c);
        tot = 0;
        for (int i = 0; i < 2; i++) begin
            k = $urandom_range(12, 1);
            tot += k;
            burst(k);
            @(posedge clk_i);
            ctog <= 1'b1;
            @(posedge clk_i);
            ctog <= 1'b0;
            settle;
            cmp("wake", 32'h1, 32'(wake));
            cmp("irq off", 32'h0, 32'(irq));
            rd("cap units", OFS_CAP_UNITS, c + 32'(tot >> 3), '1);
            rd("cap sub", OFS_CAP_SUB, 32'(tot & 7), '1);
            wr(OFS_MASK, 32'h8);
            settle;
            cmp("cap irq", 32'h1, 32'(irq));
            wr(OFS_STATUS, 32'h8);
            wr(OFS_MASK, 32'h0);
            settle;
            cmp("wake off", 32'h0, 32'(wake));
        end
        $display("test capture done");
        // One whole second of crystal ticks, alarm on the following count
        s = 32'($urandom_range(65535, 0));
        wr(OFS_CTRL, SEN);
        wr(OFS_SEC_COUNT, s);
        wr(OFS_SEC_ALARM, s + 32'h1);
        wr(OFS_CTRL, SEN | (32'h1 << CTL_SEC_ARM));
        wr(OFS_STATUS, 32'h1F);
        burst(32767);
        rd("sec early", OFS_SEC_COUNT, s, '1);
        rd("sec alarm early", OFS_STATUS, 32'h0, 32'h1);
        burst(1);
        rd("sec count", OFS_SEC_COUNT, s + 32'h1, '1);
        rd("sec alarm", OFS_STATUS, 32'h1, 32'h1);
        rd("arm cleared", OFS_CTRL, SEN, '1);
        settle;
        cmp("sec wake", 32'h1, 32'(wake));
        $display("test seconds done");
        stop_test;
    end
endmodule
`default_nettype wire
